/* File: hrmc_ctrl.sv */
/*
 High-resolution single-hit interval mode control with AXI4-Lite registers.
 Assumes pins are asynchronous to aclk and a 10 MHz aclk.
*/
// Our own choices: the AXI4-Lite slave port and the register addresses.
// How it works
// - In the mode each stop channel captures one hit per measurement.
// - A channel with both edge enables cleared records nothing.
// - One hardware pin per stop input and edge blocks that edge.
// - After reset inputs stay closed until the power bit is set; then they are open before any start.
// - Stop hold option keeps stops closed until a start plus a short gap.
// - Only the first start is the time reference of a measurement.
// - Start lock closes the start channel after the first start.
// - An 18-bit start offset is added to every stop result.
// - Results reach the FIFOs 400 ns after the trigger; data valid within 1 us.
// - Master reset clears all but configuration; inputs reopen one 100 ns cycle later (40 ns rounded up).
// - Post-processing starts only on trigger pin rise or trigger bit.
// - First result FIFO reads at index 8, second at index 9.
`timescale 1ns/1ps
`include "hrmc_cfg.svh"
module hrmc_ctrl (
   input  wire logic        aclk,
   input  wire logic        aresetn,
   input  wire logic [5:0]  awaddr,
   input  wire logic        awvalid,
   output logic             awready,
   input  wire logic [31:0] wdata,
   input  wire logic [3:0]  wstrb,
   input  wire logic        wvalid,
   output logic             wready,
   output logic [1:0]       bresp,
   output logic             bvalid,
   input  wire logic        bready,
   input  wire logic [5:0]  araddr,
   input  wire logic        arvalid,
   output logic             arready,
   output logic [31:0]      rdata,
   output logic [1:0]       rresp,
   output logic             rvalid,
   input  wire logic        rready,
   input  wire logic        start_in,
   input  wire logic [1:0]  stop_in,
   input  wire logic        trig_in,
   input  wire logic [3:0]  stop_input_disable_pin,
   output logic             result_fifo1_empty,
   output logic             result_fifo2_empty,
   output logic             result_fifo1_level_reached,
   output logic             result_fifo2_level_reached,
   output logic             diff_input_power_on
);
   hrmc_pkg::hrmc_state_s q;
   hrmc_pkg::hrmc_state_s n;
   logic [7:0]        pins;
   logic [7:0]        stable;
   logic [7:0]        rise;
   logic [7:0]        fall;
   logic [1:0]        emp;
   logic [1:0]        lf;
   logic [1:0]        full;
   logic [1:0]        hit_ok;
   logic [1:0][22:0]  res;
   logic              hi_res;
   logic              gate_open;
   logic              start_go;
   logic              trig_go;
   logic              mr_go;
   logic              wr_go;
   logic              rd_go;
   logic [31:0]       wv;

   // ------------------------------------------------------------------
   // Flags and bus handshakes
   // ------------------------------------------------------------------
   // Pin order: start, stop1, stop2, trigger, then the four disable pins
   assign pins = {stop_input_disable_pin, trig_in, stop_in, start_in};
   // Outputs of the second and third stages; the first stage feeds nothing else
   assign stable = ~(q.s2 ^ q.s3);
   assign rise = stable & q.s2 & ~q.f;
   assign fall = stable & ~q.s2 & q.f;
   for (genvar c = 0; c < 2; c++) begin : g_flag
      assign emp[c] = (q.wp[c] == q.rp[c]);
      assign full[c] = (5'(q.wp[c] - q.rp[c]) == 5'(`HRMC_DEPTH));
      assign lf[c] = ({3'h0, 5'(q.wp[c] - q.rp[c])} >= q.fill);
   end
   assign hi_res = q.hires_en && (q.subdiv == `HRMC_SUBDIV_HI);
   assign gate_open = (q.mr_cnt == 4'h0);
   assign wr_go = awvalid && wvalid && !q.bvalid;
   assign rd_go = arvalid && !q.rvalid;
   assign awready = wr_go;
   assign wready = wr_go;
   assign arready = !q.rvalid;
   assign bvalid = q.bvalid;
   assign bresp = q.bresp;
   assign rvalid = q.rvalid;
   assign rresp = q.rresp;
   assign rdata = q.rdata;
   assign result_fifo1_empty = emp[0];
   assign result_fifo2_empty = emp[1];
   assign result_fifo1_level_reached = lf[0];
   assign result_fifo2_level_reached = lf[1];
   assign diff_input_power_on = q.pwr;

   // Register image as software sees it; write-only strobes read as zero
   function automatic logic [31:0] img(input logic [3:0] i);
      unique case (i)
         `HRMC_IDX_EDGE:   img = {26'h0, q.edge_en};
         `HRMC_IDX_DIS:    img = {23'h0, q.soft_dis};
         `HRMC_IDX_SUBDIV: img = {27'h0, q.subdiv};
         `HRMC_IDX_MODE:   img = {30'h0, q.quiet_en, q.hires_en};
         `HRMC_IDX_OFFS:   img = {12'h0, q.start_lock, q.stop_hold, q.offset};
         `HRMC_IDX_LVL:    img = {q.pwr, 23'h0, q.fill};
         `HRMC_IDX_STAT:   img = {26'h0, q.busy, q.started, lf, emp};
         default:          img = 32'h0000_0000;
      endcase
   endfunction : img

   // Byte-lane merge for partial writes
   function automatic logic [31:0] wmerge(input logic [31:0] o);
      wmerge = o;
      for (int i = 0; i < 4; i++) begin
         if (wstrb[i]) begin
            wmerge[8*i +: 8] = wdata[8*i +: 8];
         end
      end
   endfunction : wmerge

   // ------------------------------------------------------------------
   // Next state
   // ------------------------------------------------------------------
   always_comb begin
      n = q;
      trig_go = 1'b0;
      mr_go = 1'b0;
      wv = wmerge(img(awaddr[5:2]));
      n.s1 = pins;
      n.s2 = q.s1;
      n.s3 = q.s2;
      n.f = (q.f & ~stable) | (q.s2 & stable);

      // Register writes; the reply waits until the master takes it
      n.bvalid = q.bvalid && !bready;
      if (wr_go) begin
         n.bvalid = 1'b1;
         n.bresp = 2'b00;
         unique case (awaddr[5:2])
            `HRMC_IDX_EDGE:   n.edge_en = wv[5:0];
            `HRMC_IDX_DIS:    n.soft_dis = wv[8:0];
            `HRMC_IDX_SUBDIV: n.subdiv = wv[4:0];
            `HRMC_IDX_MODE: begin
               n.hires_en = wv[`HRMC_MODE_HIRES];
               n.quiet_en = wv[`HRMC_MODE_QUIET];
               mr_go = wv[`HRMC_MODE_MRST];
            end
            `HRMC_IDX_OFFS: begin
               n.offset = wv[17:0];
               n.stop_hold = wv[`HRMC_OFFS_HOLD];
               n.start_lock = wv[`HRMC_OFFS_LOCK];
               trig_go = wv[`HRMC_OFFS_TRIG];
            end
            `HRMC_IDX_LVL: begin
               n.fill = wv[7:0];
               n.pwr = wv[`HRMC_LVL_PWR];
            end
            default: n.bresp = 2'b10;
         endcase
      end

      // Register reads; a result FIFO read pops one word
      n.rvalid = q.rvalid && !rready;
      if (rd_go) begin
         n.rvalid = 1'b1;
         n.rresp = 2'b00;
         n.rdata = img(araddr[5:2]);
         unique case (araddr[5:2])
            `HRMC_IDX_EDGE, `HRMC_IDX_DIS, `HRMC_IDX_SUBDIV, `HRMC_IDX_MODE,
            `HRMC_IDX_OFFS, `HRMC_IDX_LVL, `HRMC_IDX_STAT: n.rresp = 2'b00;
            `HRMC_IDX_FIFO1, `HRMC_IDX_FIFO2: begin
               // An empty FIFO answers zero and is left untouched
               for (int c = 0; c < 2; c++) begin
                  if (araddr[2] == c[0] && !emp[c]) begin
                     n.rdata = {9'h0, q.mem[c][q.rp[c][3:0]]};
                     n.rp[c] = 5'(q.rp[c] + 5'h1);
                  end
               end
            end
            default: n.rresp = 2'b10;
         endcase
      end

      // Start: the first accepted edge is the only reference
      start_go = ((q.edge_en[0] && rise[0]) || (q.edge_en[3] && fall[0]))
                 && !(&q.soft_dis[2:0]) && q.pwr && gate_open
                 && !(q.start_lock && q.started);
      if (q.hold_cnt != 4'h0) begin
         n.hold_cnt = 4'(q.hold_cnt - 4'h1);
      end
      if (q.timer <= 10'(`HRMC_RANGE_CYC)) begin
         n.timer = 10'(q.timer + 10'h1);
      end
      if (start_go && !q.started) begin
         n.started = 1'b1;
         n.timer = 10'h000;
         n.hold_cnt = 4'(`HRMC_HOLD_CYC);
      end

      // Stops: edge enables, pin and soft disables, hold and range gates
      for (int c = 0; c < 2; c++) begin
         res[c] = 23'(q.timer) + 23'(q.offset);
         hit_ok[c] = ((q.edge_en[c+1] && rise[c+1] && !q.f[4+2*c])
                     || (q.edge_en[c+4] && fall[c+1] && !q.f[5+2*c]))
                     && !(&q.soft_dis[3*c+3 +: 3]) && q.pwr && gate_open
                     && (!q.stop_hold || (q.started && q.hold_cnt == 4'h0))
                     && (!q.started || q.timer <= 10'(`HRMC_RANGE_CYC))
                     && !(hi_res && q.taken[c]);
         if (hit_ok[c]) begin
            n.taken[c] = 1'b1;
            if (q.quiet_en) begin
               // Held until the trigger; later hits are dropped while one is held
               if (!q.held_v[c]) begin
                  n.held[c] = res[c];
                  n.held_v[c] = 1'b1;
               end
            end else if (!full[c]) begin
               n.mem[c][q.wp[c][3:0]] = res[c];
               n.wp[c] = 5'(q.wp[c] + 5'h1);
            end
         end
      end

      // Deferred post-processing, started only by a trigger
      trig_go = (trig_go || rise[3]) && q.quiet_en && !q.busy;
      if (trig_go) begin
         n.busy = 1'b1;
         n.pp_cnt = 4'(`HRMC_PP_CYC);
      end else if (q.busy) begin
         n.pp_cnt = 4'(q.pp_cnt - 4'h1);
         if (q.pp_cnt == 4'h1) begin
            n.busy = 1'b0;
            for (int c = 0; c < 2; c++) begin
               if (q.held_v[c] && !full[c]) begin
                  n.mem[c][q.wp[c][3:0]] = q.held[c];
                  n.wp[c] = 5'(q.wp[c] + 5'h1);
               end
            end
            n.held_v = 2'b00;
         end
      end

      // Master reset keeps configuration, clears the rest, shuts inputs briefly
      if (q.mr_cnt != 4'h0) begin
         n.mr_cnt = 4'(q.mr_cnt - 4'h1);
      end
      if (mr_go) begin
         n.started = 1'b0;
         n.timer = 10'h000;
         n.hold_cnt = 4'h0;
         n.taken = 2'b00;
         n.held_v = 2'b00;
         n.busy = 1'b0;
         n.pp_cnt = 4'h0;
         n.wp = '0;
         n.rp = '0;
         n.mr_cnt = 4'(`HRMC_MR_CYC);
      end
   end

   // ------------------------------------------------------------------
   // State register
   // ------------------------------------------------------------------
   // Synchronous reset; inputs stay closed afterwards until the power bit is set
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         q <= '0;
         q.edge_en <= `HRMC_EDGE_RST;
      end else begin
         q <= n;
      end
   end

   // ------------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------------
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);

   property p_one_stop;
      hi_res && q.taken[0] && !mr_go |=> hi_res |-> !hit_ok[0];
   endproperty
   a_one_stop: assert property (p_one_stop) else $error("second stop taken");

   property p_edge_off;
      !q.edge_en[1] && !q.edge_en[4] |-> !hit_ok[0];
   endproperty
   a_edge_off: assert property (p_edge_off) else $error("disabled channel hit");

   property p_pin_block;
      q.f[6] && q.f[7] |-> !hit_ok[1];
   endproperty
   a_pin_block: assert property (p_pin_block) else $error("pin did not block");

   property p_hold;
      q.stop_hold && !q.started |-> hit_ok == 2'b00;
   endproperty
   a_hold: assert property (p_hold) else $error("stop before start");

   property p_first_start;
      q.started && !mr_go |=> q.started && q.timer >= $past(q.timer);
   endproperty
   a_first_start: assert property (p_first_start) else $error("reference moved");

   property p_offset;
      hit_ok[0] && q.quiet_en && !q.held_v[0] && !mr_go
         |=> q.held[0] == 23'($past(q.timer)) + 23'($past(q.offset));
   endproperty
   a_offset: assert property (p_offset) else $error("offset not added");

   property p_valid_time;
      trig_go && !mr_go |=> q.busy [*4] ##1 !q.busy;
   endproperty
   a_valid_time: assert property (p_valid_time) else $error("late data");

   property p_range;
      q.started && q.timer > 10'(`HRMC_RANGE_CYC) |-> hit_ok == 2'b00;
   endproperty
   a_range: assert property (p_range) else $error("hit out of range");

   property p_mreset;
      mr_go |=> !q.started && emp == 2'b11 && !gate_open;
   endproperty
   a_mreset: assert property (p_mreset) else $error("master reset failed");

   property p_no_auto;
      !trig_go && !q.busy |=> !q.busy;
   endproperty
   a_no_auto: assert property (p_no_auto) else $error("untriggered run");

   property p_fifo_read;
      rd_go && araddr[5:2] == `HRMC_IDX_FIFO1 && !emp[0] && !mr_go
         |=> q.rvalid && q.rp[0] == 5'($past(q.rp[0]) + 5'h1);
   endproperty
   a_fifo_read: assert property (p_fifo_read) else $error("no pop");
endmodule : hrmc_ctrl

/* File: hrmc_cfg.svh */
/*
 Register indices, field positions, reset values and timing counts of the
 high-resolution interval mode control block.
 Assumes a 10 MHz clock; byte address of a register is four times its index.
*/
`ifndef HRMC_CFG_SVH
`define HRMC_CFG_SVH

// ----------------------------------------------------------------------
// Register indices (byte address = index * 4)
// ----------------------------------------------------------------------
`define HRMC_IDX_EDGE   4'h0
`define HRMC_IDX_DIS    4'h2
`define HRMC_IDX_SUBDIV 4'h3
`define HRMC_IDX_MODE   4'h4
`define HRMC_IDX_OFFS   4'h5
`define HRMC_IDX_LVL    4'h6
`define HRMC_IDX_FIFO1  4'h8
`define HRMC_IDX_FIFO2  4'h9
`define HRMC_IDX_STAT   4'hA

// ----------------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------------
`define HRMC_MODE_HIRES 0
`define HRMC_MODE_QUIET 1
`define HRMC_MODE_MRST  2
`define HRMC_OFFS_HOLD  18
`define HRMC_OFFS_LOCK  19
`define HRMC_OFFS_TRIG  20
`define HRMC_LVL_PWR    31
`define HRMC_SUBDIV_HI  5'h1F
`define HRMC_EDGE_RST   6'h3F
`define HRMC_DEPTH      16

// ----------------------------------------------------------------------
// Timing (ns figures, cycle counts derived from the clock period except HRMC_PP_CYC, which is given directly)
// ----------------------------------------------------------------------
`define HRMC_CLK_NS     100
`define HRMC_HOLD_NS    7
`define HRMC_HOLD_CYC   ((`HRMC_HOLD_NS + `HRMC_CLK_NS - 1) / `HRMC_CLK_NS)
`define HRMC_MR_NS      40
`define HRMC_MR_CYC     ((`HRMC_MR_NS + `HRMC_CLK_NS - 1) / `HRMC_CLK_NS)
`define HRMC_VALID_NS   1000
`define HRMC_VALID_CYC  (`HRMC_VALID_NS / `HRMC_CLK_NS)
`define HRMC_PP_CYC     4
`define HRMC_RANGE_NS   40000
`define HRMC_RANGE_CYC  (`HRMC_RANGE_NS / `HRMC_CLK_NS)

`endif

/* File: hrmc_pkg.sv */
/*
 Types of the high-resolution interval mode control block.
 Assumes hrmc_cfg.svh for sizes.
*/
`include "hrmc_cfg.svh"
package hrmc_pkg;
   // Whole state of the block, registered in one place
   typedef struct packed {
      logic [5:0]                          edge_en;
      logic [8:0]                          soft_dis;
      logic [4:0]                          subdiv;
      logic                                hires_en;
      logic                                quiet_en;
      logic [17:0]                         offset;
      logic                                stop_hold;
      logic                                start_lock;
      logic [7:0]                          fill;
      logic                                pwr;
      logic [7:0]                          s1;
      logic [7:0]                          s2;
      logic [7:0]                          s3;
      logic [7:0]                          f;
      logic                                started;
      logic [9:0]                          timer;
      logic [3:0]                          hold_cnt;
      logic [3:0]                          mr_cnt;
      logic [3:0]                          pp_cnt;
      logic                                busy;
      logic [1:0]                          taken;
      logic [1:0]                          held_v;
      logic [1:0][22:0]                    held;
      logic [1:0][`HRMC_DEPTH-1:0][22:0]   mem;
      logic [1:0][4:0]                     wp;
      logic [1:0][4:0]                     rp;
      logic                                bvalid;
      logic [1:0]                          bresp;
      logic                                rvalid;
      logic [1:0]                          rresp;
      logic [31:0]                         rdata;
   } hrmc_state_s;
endpackage : hrmc_pkg

/* File: hrmc_pin_src.sv */
/*
 Pulse source standing in for the measurement front end: start, stop and
 trigger pins of the interval mode control block.
 Assumes aclk is the block clock; the bench calls pulse() to make one pulse.
*/
`timescale 1ns/1ps
module hrmc_pin_src (
   input  wire logic       aclk,
   output logic            start_in,
   output logic [1:0]      stop_in,
   output logic            trig_in
);
   // ----------------------------------------------------------------
   // Pin drivers
   // ----------------------------------------------------------------
   logic [3:0]             pins_q = 4'h0;

   // Pins idle low between pulses, never left floating
   assign start_in = pins_q[0];
   assign stop_in  = pins_q[2:1];
   assign trig_in  = pins_q[3];

   // Pulse of 3 cycles high and 3 low: the synchroniser needs 2 at least
   task automatic pulse(input int ch);
      @(posedge aclk);
      pins_q[ch] <= 1'b1;
      repeat (3) @(posedge aclk);
      pins_q[ch] <= 1'b0;
      repeat (3) @(posedge aclk);
   endtask : pulse
endmodule : hrmc_pin_src

/* File: hrmc_ctrl_tb.sv */
/*
 Self-checking bench of the interval mode control block.
 Assumes hrmc_cfg.svh on the include path and a 100 ns aclk.
*/
`timescale 1ns/1ps
`include "hrmc_cfg.svh"
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin n_fail++; \
   $display("Error %s expected %0h seen %0h", nm, e, g); end end
module hrmc_ctrl_tb;
   // ----------------------------------------------------------------
   // Signals
   // ----------------------------------------------------------------
   localparam logic [31:0] OFFS = 32'h0003_FF00;
   logic        aclk = 1'b0, aresetn = 1'b0;
   logic [5:0]  awaddr = 6'h00, araddr = 6'h00;
   logic [31:0] wdata = 32'h0000_0000, rdata;
   logic [3:0]  wstrb = 4'hF, stop_input_disable_pin = 4'h0;
   logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
   logic        arvalid = 1'b0, rready = 1'b0;
   logic        awready, wready, bvalid, arready, rvalid, start_in, trig_in;
   logic [1:0]  bresp, rresp, stop_in;
   logic        result_fifo1_empty, result_fifo2_empty, diff_input_power_on;
   logic        result_fifo1_level_reached, result_fifo2_level_reached;
   logic [31:0] mode_v = 32'h0000_0000;
   int          n_fail = 0;
   int          checked = 0;

   hrmc_ctrl hrmc_ctrl_inst (
      .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
      .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
      .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
      .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
      .rresp(rresp), .rvalid(rvalid), .rready(rready), .start_in(start_in),
      .stop_in(stop_in), .trig_in(trig_in),
      .stop_input_disable_pin(stop_input_disable_pin),
      .result_fifo1_empty(result_fifo1_empty),
      .result_fifo2_empty(result_fifo2_empty),
      .result_fifo1_level_reached(result_fifo1_level_reached),
      .result_fifo2_level_reached(result_fifo2_level_reached),
      .diff_input_power_on(diff_input_power_on)
   );

   hrmc_pin_src hrmc_pin_src_inst (
      .aclk(aclk), .start_in(start_in), .stop_in(stop_in), .trig_in(trig_in)
   );

   // Clock of 100 ns period
   initial begin
      forever #50 aclk = ~aclk;
   end

   // ----------------------------------------------------------------
   // Bus and timing helpers
   // ----------------------------------------------------------------
   // Ready is looked at mid-cycle, so the handshake edge is never guessed
   task automatic wr(input logic [3:0] idx, input logic [31:0] d, output logic [1:0] r);
      @(posedge aclk);
      awaddr <= {idx, 2'b00};
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do @(negedge aclk); while (!(awready && wready));
      @(posedge aclk);
      awvalid <= 1'b0;
      wvalid <= 1'b0;
      do @(negedge aclk); while (!bvalid);
      r = bresp;
      @(posedge aclk);
      bready <= 1'b0;
   endtask : wr

   task automatic rd(input logic [3:0] idx, output logic [31:0] d, output logic [1:0] r);
      @(posedge aclk);
      araddr <= {idx, 2'b00};
      arvalid <= 1'b1;
      rready <= 1'b1;
      do @(negedge aclk); while (!arready);
      @(posedge aclk);
      arvalid <= 1'b0;
      do @(negedge aclk); while (!rvalid);
      d = rdata;
      r = rresp;
      @(posedge aclk);
      rready <= 1'b0;
   endtask : rd

   task automatic w(input logic [3:0] idx, input logic [31:0] d);
      logic [1:0] r;
      wr(idx, d, r);
      `CHK("bresp", 2'b00, r)
   endtask : w

   // Ends mid-cycle so that flags are compared when settled
   task automatic cyc(input int n);
      repeat (n) @(posedge aclk);
      @(negedge aclk);
   endtask : cyc

   task automatic mrst();
      w(`HRMC_IDX_MODE, mode_v | 32'h0000_0004);
      cyc(3);
   endtask : mrst

   task automatic wait_ne(input int n, output logic ok);
      ok = 1'b0;
      repeat (n) begin
         @(negedge aclk);
         if (result_fifo1_empty === 1'b0) ok = 1'b1;
      end
   endtask : wait_ne

   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   task automatic s_reset();
      logic [31:0] d;
      logic [1:0]  r;
      rd(`HRMC_IDX_EDGE, d, r);
      `CHK("edge_rst", 32'h0000_003F, d)
      rd(4'hF, d, r);
      `CHK("unmapped", 2'b10, r)
      wr(`HRMC_IDX_FIFO1, 32'h0000_0001, r);
      `CHK("fifo_write", 2'b10, r)
      `CHK("empty_rst", 2'b11, {result_fifo2_empty, result_fifo1_empty})
      `CHK("pwr_rst", 1'b0, diff_input_power_on)
      w(`HRMC_IDX_LVL, 32'h8000_0000);
      cyc(1);
      `CHK("pwr_on", 1'b1, diff_input_power_on)
   endtask : s_reset

   task automatic s_nonquiet();
      logic [31:0] d, iv;
      logic [1:0]  r;
      w(`HRMC_IDX_EDGE, 32'h0000_0007);
      w(`HRMC_IDX_OFFS, OFFS);
      w(`HRMC_IDX_LVL, 32'h8000_0001);
      cyc(1);
      `CHK("lvl_none", 1'b0, result_fifo1_level_reached)
      hrmc_pin_src_inst.pulse(1);
      cyc(6);
      `CHK("pre_start", 1'b0, result_fifo1_empty)
      `CHK("lvl1", 1'b1, result_fifo1_level_reached)
      `CHK("lvl2", 1'b0, result_fifo2_level_reached)
      rd(`HRMC_IDX_FIFO1, d, r);
      `CHK("pad_bits", 9'h000, d[31:23])
      hrmc_pin_src_inst.pulse(0);
      cyc(4);
      hrmc_pin_src_inst.pulse(2);
      cyc(8);
      rd(`HRMC_IDX_FIFO2, d, r);
      iv = (d & 32'h007F_FFFF) - OFFS;
      `CHK("interval", 1'b1, (iv >= 9 && iv <= 13))
   endtask : s_nonquiet

   task automatic s_gate();
      logic [31:0] d;
      logic [1:0]  r;
      mrst();
      w(`HRMC_IDX_EDGE, 32'h0000_0005);
      @(posedge aclk);
      stop_input_disable_pin <= 4'b0100;
      hrmc_pin_src_inst.pulse(0);
      hrmc_pin_src_inst.pulse(1);
      hrmc_pin_src_inst.pulse(2);
      cyc(8);
      `CHK("gated", 2'b11, {result_fifo2_empty, result_fifo1_empty})
      mrst();
      w(`HRMC_IDX_EDGE, 32'h0000_0007);
      w(`HRMC_IDX_DIS, 32'h0000_0038);
      @(posedge aclk);
      stop_input_disable_pin <= 4'b0000;
      hrmc_pin_src_inst.pulse(0);
      hrmc_pin_src_inst.pulse(1);
      hrmc_pin_src_inst.pulse(2);
      cyc(8);
      `CHK("soft_dis", 2'b01, {result_fifo2_empty, result_fifo1_empty})
      w(`HRMC_IDX_DIS, 32'h0000_0000);
      mrst();
      `CHK("mrst_clr", 2'b11, {result_fifo2_empty, result_fifo1_empty})
      rd(`HRMC_IDX_EDGE, d, r);
      `CHK("cfg_kept", 32'h0000_0007, d)
   endtask : s_gate

   task automatic s_hold();
      logic [31:0] d;
      logic [1:0]  r;
      w(`HRMC_IDX_OFFS, OFFS | 32'h0004_0000);
      hrmc_pin_src_inst.pulse(1);
      cyc(6);
      `CHK("held", 1'b1, result_fifo1_empty)
      hrmc_pin_src_inst.pulse(0);
      hrmc_pin_src_inst.pulse(1);
      cyc(8);
      `CHK("opened", 1'b0, result_fifo1_empty)
      rd(`HRMC_IDX_FIFO1, d, r);
      cyc(400);
      hrmc_pin_src_inst.pulse(2);
      cyc(8);
      `CHK("range", 1'b1, result_fifo2_empty)
   endtask : s_hold

   // Both edges enabled: a pulse brings two edges, only one may be kept
   task automatic s_hires();
      logic [31:0] d;
      logic [1:0]  r;
      logic        ok;
      w(`HRMC_IDX_SUBDIV, 32'h0000_001F);
      mode_v = 32'h0000_0003;
      mrst();
      w(`HRMC_IDX_EDGE, 32'h0000_003F);
      w(`HRMC_IDX_OFFS, OFFS);
      hrmc_pin_src_inst.pulse(0);
      hrmc_pin_src_inst.pulse(1);
      hrmc_pin_src_inst.pulse(1);
      hrmc_pin_src_inst.pulse(2);
      cyc(6);
      `CHK("quiet", 2'b11, {result_fifo2_empty, result_fifo1_empty})
      w(`HRMC_IDX_OFFS, OFFS | 32'h0010_0000);
      wait_ne(`HRMC_VALID_CYC, ok);
      `CHK("valid_time", 1'b1, ok)
      rd(`HRMC_IDX_FIFO1, d, r);
      cyc(1);
      `CHK("one_hit1", 1'b1, result_fifo1_empty)
      `CHK("hit2", 1'b0, result_fifo2_empty)
      rd(`HRMC_IDX_FIFO2, d, r);
      cyc(1);
      `CHK("one_hit2", 1'b1, result_fifo2_empty)
      mrst();
   endtask : s_hires

   // The pulse task spends 6 cycles, taken off the allowed delay
   task automatic s_trig();
      logic ok;
      hrmc_pin_src_inst.pulse(0);
      hrmc_pin_src_inst.pulse(1);
      cyc(6);
      `CHK("no_auto", 1'b1, result_fifo1_empty)
      hrmc_pin_src_inst.pulse(3);
      wait_ne(`HRMC_VALID_CYC - 6, ok);
      `CHK("pin_trig", 1'b1, ok)
   endtask : s_trig

   // ----------------------------------------------------------------
   // Sequence, verdict and watchdog
   // ----------------------------------------------------------------
   task automatic conclude();
      $display("Checks %0d mismatches %0d", checked, n_fail);
      if (n_fail == 0 && checked > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask : conclude

   // Main sequence after 4 cycles of reset
   initial begin
      repeat (4) @(posedge aclk);
      aresetn <= 1'b1;
      s_reset();
      s_nonquiet();
      s_gate();
      s_hold();
      s_hires();
      s_trig();
      conclude();
   end

   // Tests need about 1000 cycles; a hang is cut well beyond that
   initial begin
      repeat (20000) @(posedge aclk);
      n_fail++;
      conclude();
   end
endmodule : hrmc_ctrl_tb
